// [core/cicd_defs.vh]
// constants for the cpu interface control and deactivate block
`ifndef CICD_DEFS_VH
`define CICD_DEFS_VH
// ----------------------------------------------------------------
// system register encodings
// ----------------------------------------------------------------
`define CICD_COPROC 4'hF
`define CICD_OPC1 3'h0
`define CICD_CRN 4'hC
`define CICD_CTL_CRM 4'hC
`define CICD_CTL_OPC2 3'h4
`define CICD_DIR_CRM 4'hB
`define CICD_DIR_OPC2 3'h1
// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CICD_F_IDW_HI 13
`define CICD_F_IDW_LO 11
`define CICD_F_PRI_HI 10
`define CICD_F_PRI_LO 8
`define CICD_F_MASK_HINT_ENABLE 6
`define CICD_F_EOIM 1
`define CICD_F_COMMON_BINARY_POINT 0
`define CICD_IDW_16 3'h0
`define CICD_IDW_24 3'h1
`define CICD_ID_HI 23
`define CICD_ID16_HI 15
// priority bits minus one: 5 bits with two security states, 4 with one
`define CICD_PRI_TWO_SEC 3'h4
`define CICD_PRI_ONE_SEC 3'h3
// ----------------------------------------------------------------
// access outcome codes
// ----------------------------------------------------------------
`define CICD_RES_OK 3'h0
`define CICD_RES_UNDEF 3'h1
`define CICD_RES_TRAP_EL2 3'h2
`define CICD_RES_TRAP_EL3 3'h3
`define CICD_RES_VIRT 3'h4
`define CICD_RES_IGNORED 3'h5
`define CICD_RES_NOREG 3'h6
`endif

// [core/cicd_access_check.v]
// decides the outcome of one system register access
`timescale 1ns/1ns
`include "cicd_defs.vh"
module cicd_access_check (
  input wire i_is_ctl,
  input wire i_is_dir,
  input wire [1:0] i_el,
  input wire i_secure,
  input wire i_sre,
  input wire i_hyp_fiq_route,
  input wire i_hyp_irq_route,
  input wire i_hyp_trap_common,
  input wire i_el3_present,
  input wire i_el3_wide,
  input wire i_mon_fiq,
  input wire i_mon_irq,
  input wire i_id_group1,
  output reg [2:0] o_result
);
  wire ns_el1;
  assign ns_el1 = (i_el == 2'h1) && !i_secure;
  always @*
  begin
    o_result = `CICD_RES_OK;
    if (!i_is_ctl && !i_is_dir)
      o_result = `CICD_RES_NOREG;
    else if (!i_sre)
      o_result = `CICD_RES_UNDEF;
    else if (i_is_ctl && ns_el1 && (i_hyp_fiq_route || i_hyp_irq_route))
      o_result = `CICD_RES_VIRT;
    else if (i_is_dir && ns_el1 &&
             ((i_hyp_fiq_route && !i_id_group1) || (i_hyp_irq_route && i_id_group1)))
      o_result = `CICD_RES_VIRT;
    else if (ns_el1 && i_hyp_trap_common)
      o_result = `CICD_RES_TRAP_EL2;
    else if (i_el3_present && i_el3_wide && i_secure && (i_el == 2'h1) &&
             i_mon_fiq && i_mon_irq)
      o_result = `CICD_RES_TRAP_EL3;
  end
endmodule // cicd_access_check

// [core/cicd_ctl_bank.v]
// banked split end-of-interrupt mode bits, one per security state
`timescale 1ns/1ns
`include "cicd_defs.vh"
module cicd_ctl_bank (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_wr,
  input wire i_secure,
  input wire i_wdata,
  output wire o_mode
);
  reg [1:0] bank;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_bank
      always @(posedge i_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
          bank[g] <= 1'b0;
        else if (i_wr && (i_secure == (g != 0)))
          bank[g] <= i_wdata;
      end
    end
  endgenerate
  assign o_mode = i_secure ? bank[1] : bank[0];
endmodule // cicd_ctl_bank

// [core/cicd_top.v]
// cpu interface control register and deactivate register logic
// How it works
// - priority bit count at 10:8 is read-only and gives implemented bits minus one
// - two security states implement five priority bits
// - single security state implements four priority bits
// - priority bit count ignores access security state and single-security setting
// - mask hint enable bit 6 gates the priority mask distribution hint
// - with top level present, hint and common point writable only in single-security
// - without top level, bits are writable resetting zero, or fixed per parameter
// - split mode zero: end-of-interrupt writes drop priority and deactivate
// - split mode one: end-of-interrupt drops only; deactivate register deactivates
// - split mode kept per security state; visible bit is current state's copy
// - common point zero: own binary point per group; one: group zero governs both
// - control register at coproc 1111, opc1 000, CRn 1100, CRm 1100, opc2 100
// - non-secure level one with hypervisor routing accesses virtual control register
// - deactivate register write-only, bits 31:24 reserved, 23:0 interrupt identifier
// - identifier 16 or 24 bits; with 16, bits 23:16 are zero
// - deactivate write in split mode zero is ignored, may raise system error
// - deactivate without prior end still deactivates; active priority stays set
// - deactivate register at coproc 1111, opc1 000, CRn 1100, CRm 1011, opc2 001
// - non-secure level one deactivate goes virtual by routing bit and group
// - disabled system registers make writes undefined; common trap sends to level two
// - secure level one deactivate traps to top level when both monitor routes set
// - identifier width field: 000 for 16 bits, 001 for 24 bits
`timescale 1ns/1ns
`include "cicd_defs.vh"
module cicd_top #(
  parameter TWO_SEC = 1,
  parameter ID24 = 1,
  parameter EL3_PRESENT = 1,
  parameter FIXED_MASK_HINT_ENABLE = 0,
  parameter FIXED_COMMON_BINARY_POINT = 0,
  parameter FIXED_EOIM = 0,
  parameter FIXED_VALUE = 0,
  parameter SEI_PRESENT = 1
) (
  input wire I_CORE_CLK,
  input wire I_RST_N,
  input wire i_SYS_VALID,
  input wire i_SYS_WRITE,
  input wire [3:0] i_SYS_COPROC,
  input wire [2:0] i_SYS_OPC1,
  input wire [3:0] i_SYS_CRN,
  input wire [3:0] i_SYS_CRM,
  input wire [2:0] i_SYS_OPC2,
  input wire [31:0] i_SYS_WDATA,
  input wire [1:0] i_SYS_EL,
  input wire i_SYS_SECURE,
  input wire i_SYSREG_ENABLE,
  input wire i_HYP_FIQ_ROUTE,
  input wire i_HYP_IRQ_ROUTE,
  input wire i_HYP_TRAP_COMMON,
  input wire i_EL3_WIDE,
  input wire i_MON_FIQ,
  input wire i_MON_IRQ,
  input wire i_DIST_SINGLE_SECURITY,
  input wire i_ID_GROUP1,
  input wire i_EOI_WRITE,
  output reg o_SYS_DONE,
  output reg [2:0] o_SYS_RESULT,
  output reg [31:0] o_SYS_RDATA,
  output reg o_MASK_HINT_ENABLE,
  output reg o_COMMON_BINARY_POINT,
  output wire o_SPLIT_EOI_MODE,
  output reg o_PRIORITY_DROP,
  output reg o_DEACTIVATE,
  output reg [23:0] o_DEACTIVATE_ID,
  output reg o_SYSTEM_ERROR_IRQ
);
  // ----------------------------------------------------------------
  // synchronise the distributor security setting
  // ----------------------------------------------------------------
  reg ds_meta;
  reg ds_sync;
  always @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      ds_meta <= 1'b0;
      ds_sync <= 1'b0;
    end
    else
    begin
      ds_meta <= i_DIST_SINGLE_SECURITY;
      ds_sync <= ds_meta;
    end
  end
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire coproc_hit;
  wire opc1_hit;
  wire crn_hit;
  wire ctl_enc_hit;
  wire dir_enc_hit;
  wire base_hit;
  wire is_ctl;
  wire is_dir;
  wire [2:0] result;
  assign coproc_hit = (i_SYS_COPROC == `CICD_COPROC);
  assign opc1_hit = (i_SYS_OPC1 == `CICD_OPC1);
  assign crn_hit = (i_SYS_CRN == `CICD_CRN);
  assign ctl_enc_hit = (i_SYS_CRM == `CICD_CTL_CRM) &&
                       (i_SYS_OPC2 == `CICD_CTL_OPC2);
  assign dir_enc_hit = (i_SYS_CRM == `CICD_DIR_CRM) &&
                       (i_SYS_OPC2 == `CICD_DIR_OPC2);
  assign base_hit = i_SYS_VALID && coproc_hit && opc1_hit && crn_hit;
  // the deactivate register is write-only, so a read there matches no register
  assign is_ctl = base_hit && ctl_enc_hit;
  assign is_dir = base_hit && i_SYS_WRITE && dir_enc_hit;
  cicd_access_check cicd_access_check_i (
    .i_is_ctl(is_ctl),
    .i_is_dir(is_dir),
    .i_el(i_SYS_EL),
    .i_secure(i_SYS_SECURE),
    .i_sre(i_SYSREG_ENABLE),
    .i_hyp_fiq_route(i_HYP_FIQ_ROUTE),
    .i_hyp_irq_route(i_HYP_IRQ_ROUTE),
    .i_hyp_trap_common(i_HYP_TRAP_COMMON),
    .i_el3_present(EL3_PRESENT != 0),
    .i_el3_wide(i_EL3_WIDE),
    .i_mon_fiq(i_MON_FIQ),
    .i_mon_irq(i_MON_IRQ),
    .i_id_group1(i_ID_GROUP1),
    .o_result(result)
  );
  wire ok;
  wire ctl_wr;
  wire ctl_rd;
  wire dir_wr;
  assign ok = (result == `CICD_RES_OK);
  assign ctl_wr = ok && is_ctl && i_SYS_WRITE;
  assign ctl_rd = ok && is_ctl && !i_SYS_WRITE;
  assign dir_wr = ok && is_dir;
  // ----------------------------------------------------------------
  // writability of control bits
  // ----------------------------------------------------------------
  localparam MASK_HINT_ENABLE_FIXED = ((FIXED_MASK_HINT_ENABLE != 0) && (EL3_PRESENT == 0)) ? 1 : 0;
  localparam COMMON_BINARY_POINT_FIXED = ((FIXED_COMMON_BINARY_POINT != 0) && (EL3_PRESENT == 0)) ? 1 : 0;
  // a fixed bit leaves reset already at its constant
  localparam [0:0] MASK_HINT_ENABLE_RST = ((MASK_HINT_ENABLE_FIXED != 0) && (FIXED_VALUE != 0)) ? 1'b1 : 1'b0;
  localparam [0:0] COMMON_BINARY_POINT_RST = ((COMMON_BINARY_POINT_FIXED != 0) && (FIXED_VALUE != 0)) ? 1'b1 : 1'b0;
  wire cfg_wr_ok;
  wire mask_hint_enable_wr_ok;
  wire common_binary_point_wr_ok;
  wire eoim_wr_ok;
  wire fixed_bit;
  reg next_mask_hint_enable;
  reg next_common_binary_point;
  assign fixed_bit = (FIXED_VALUE != 0);
  assign cfg_wr_ok = (EL3_PRESENT != 0) ? ds_sync : 1'b1;
  assign mask_hint_enable_wr_ok = cfg_wr_ok && (MASK_HINT_ENABLE_FIXED == 0);
  assign common_binary_point_wr_ok = cfg_wr_ok && (COMMON_BINARY_POINT_FIXED == 0);
  assign eoim_wr_ok = (EL3_PRESENT != 0) || (FIXED_EOIM == 0);
  always @*
  begin
    next_mask_hint_enable = o_MASK_HINT_ENABLE;
    next_common_binary_point = o_COMMON_BINARY_POINT;
    if (MASK_HINT_ENABLE_FIXED != 0)
    begin
      // a fixed bit shows its constant and ignores writes
      next_mask_hint_enable = fixed_bit;
    end
    else if (ctl_wr && mask_hint_enable_wr_ok)
    begin
      next_mask_hint_enable = i_SYS_WDATA[`CICD_F_MASK_HINT_ENABLE];
    end
    if (COMMON_BINARY_POINT_FIXED != 0)
    begin
      next_common_binary_point = fixed_bit;
    end
    else if (ctl_wr && common_binary_point_wr_ok)
    begin
      next_common_binary_point = i_SYS_WDATA[`CICD_F_COMMON_BINARY_POINT];
    end
  end
  always @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      o_MASK_HINT_ENABLE <= MASK_HINT_ENABLE_RST;
      o_COMMON_BINARY_POINT <= COMMON_BINARY_POINT_RST;
    end
    else
    begin
      o_MASK_HINT_ENABLE <= next_mask_hint_enable;
      o_COMMON_BINARY_POINT <= next_common_binary_point;
    end
  end
  wire eoim_bank;
  cicd_ctl_bank cicd_ctl_bank_i (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RST_N),
    .i_wr(ctl_wr && eoim_wr_ok),
    .i_secure(i_SYS_SECURE),
    .i_wdata(i_SYS_WDATA[`CICD_F_EOIM]),
    .o_mode(eoim_bank)
  );
  assign o_SPLIT_EOI_MODE = eoim_wr_ok ? eoim_bank : fixed_bit;
  // ----------------------------------------------------------------
  // read value of the control register
  // ----------------------------------------------------------------
  wire [2:0] pri_count;
  wire [2:0] id_width;
  reg [31:0] ctl_value;
  assign pri_count = (TWO_SEC != 0) ? `CICD_PRI_TWO_SEC : `CICD_PRI_ONE_SEC;
  assign id_width = (ID24 != 0) ? `CICD_IDW_24 : `CICD_IDW_16;
  always @*
  begin
    ctl_value = 32'h00000000;
    ctl_value[`CICD_F_IDW_HI:`CICD_F_IDW_LO] = id_width;
    ctl_value[`CICD_F_PRI_HI:`CICD_F_PRI_LO] = pri_count;
    ctl_value[`CICD_F_MASK_HINT_ENABLE] = o_MASK_HINT_ENABLE;
    ctl_value[`CICD_F_EOIM] = o_SPLIT_EOI_MODE;
    ctl_value[`CICD_F_COMMON_BINARY_POINT] = o_COMMON_BINARY_POINT;
  end
  // ----------------------------------------------------------------
  // access answer
  // ----------------------------------------------------------------
  wire dir_ignored;
  reg [2:0] next_result;
  reg [31:0] next_rdata;
  assign dir_ignored = dir_wr && !o_SPLIT_EOI_MODE;
  always @*
  begin
    next_result = result;
    next_rdata = 32'h00000000;
    if (dir_ignored)
    begin
      // the access is answered but the write has no effect
      next_result = `CICD_RES_IGNORED;
    end
    if (ctl_rd)
    begin
      next_rdata = ctl_value;
    end
  end
  always @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      o_SYS_DONE <= 1'b0;
    end
    else
    begin
      o_SYS_DONE <= i_SYS_VALID;
    end
  end
  always @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      o_SYS_RESULT <= `CICD_RES_OK;
    end
    else
    begin
      o_SYS_RESULT <= next_result;
    end
  end
  always @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      o_SYS_RDATA <= 32'h00000000;
    end
    else
    begin
      o_SYS_RDATA <= next_rdata;
    end
  end
  // ----------------------------------------------------------------
  // end-of-interrupt and deactivation outputs
  // ----------------------------------------------------------------
  wire [23:0] id_masked;
  reg next_drop;
  reg next_deact;
  reg [23:0] next_id;
  reg next_serr;
  genvar b;
  generate
    for (b = 0; b < 24; b = b + 1)
    begin : g_id
      if (b > `CICD_ID16_HI)
      begin : g_hi
        // upper identifier bits exist only in the wide configuration
        assign id_masked[b] = (ID24 != 0) && i_SYS_WDATA[b];
      end
      else
      begin : g_lo
        assign id_masked[b] = i_SYS_WDATA[b];
      end
    end
  endgenerate
  always @*
  begin
    next_drop = i_EOI_WRITE;
    next_deact = 1'b0;
    next_id = o_DEACTIVATE_ID;
    next_serr = 1'b0;
    if (i_EOI_WRITE && !o_SPLIT_EOI_MODE)
    begin
      next_deact = 1'b1;
    end
    if (dir_wr && o_SPLIT_EOI_MODE)
    begin
      // goes to the distributor even with no prior end; priority drop untouched
      next_deact = 1'b1;
      next_id = id_masked;
    end
    if (dir_ignored && (SEI_PRESENT != 0))
    begin
      next_serr = 1'b1;
    end
  end
  always @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      o_PRIORITY_DROP <= 1'b0;
    end
    else
    begin
      o_PRIORITY_DROP <= next_drop;
    end
  end
  always @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      o_DEACTIVATE <= 1'b0;
    end
    else
    begin
      o_DEACTIVATE <= next_deact;
    end
  end
  always @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      o_DEACTIVATE_ID <= 24'h000000;
    end
    else
    begin
      o_DEACTIVATE_ID <= next_id;
    end
  end
  always @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      o_SYSTEM_ERROR_IRQ <= 1'b0;
    end
    else
    begin
      o_SYSTEM_ERROR_IRQ <= next_serr;
    end
  end
endmodule // cicd_top

// [dv/cicd_chk.sv]
// assertions on the ports of the cpu interface control block
`timescale 1ns/1ns
module cicd_chk #(
  parameter TWO_SEC = 1,
  parameter ID24 = 1
) (
  input wire I_CORE_CLK,
  input wire I_RST_N,
  input wire i_SYS_VALID,
  input wire i_SYS_WRITE,
  input wire [3:0] i_SYS_CRM,
  input wire [2:0] i_SYS_OPC2,
  input wire [31:0] i_SYS_WDATA,
  input wire [1:0] i_SYS_EL,
  input wire i_SYS_SECURE,
  input wire i_SYSREG_ENABLE,
  input wire i_HYP_FIQ_ROUTE,
  input wire i_HYP_IRQ_ROUTE,
  input wire i_EOI_WRITE,
  input wire o_SYS_DONE,
  input wire [2:0] o_SYS_RESULT,
  input wire [31:0] o_SYS_RDATA,
  input wire o_MASK_HINT_ENABLE,
  input wire o_COMMON_BINARY_POINT,
  input wire o_SPLIT_EOI_MODE,
  input wire o_PRIORITY_DROP,
  input wire o_DEACTIVATE,
  input wire [23:0] o_DEACTIVATE_ID,
  input wire o_SYSTEM_ERROR_IRQ
);
  localparam [2:0] PRI = TWO_SEC ? 3'h4 : 3'h3;
  localparam [2:0] IDW = ID24 ? 3'h1 : 3'h0;
  localparam [23:0] IDM = ID24 ? 24'hFFFFFF : 24'h00FFFF;
  wire is_ctl = i_SYS_CRM == 4'hC && i_SYS_OPC2 == 3'h4;
  wire is_dir = i_SYS_CRM == 4'hB && i_SYS_OPC2 == 3'h1 && i_SYS_WRITE;
  reg rd_ctl;
  always @(posedge I_CORE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      rd_ctl <= 1'b0;
    else
      rd_ctl <= i_SYS_VALID && is_ctl && !i_SYS_WRITE;
  end
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  sequence s_ctl_virt;
    i_SYS_VALID && is_ctl && i_SYSREG_ENABLE && i_SYS_EL == 2'h1 && !i_SYS_SECURE &&
      (i_HYP_FIQ_ROUTE || i_HYP_IRQ_ROUTE);
  endsequence
  sequence s_eoi_alone;
    i_EOI_WRITE && !i_SYS_VALID;
  endsequence
  a_done_follows: assert property (i_SYS_VALID |=> o_SYS_DONE)
    else $error("done missing after request");
  a_no_stray_done: assert property (!i_SYS_VALID |=> !o_SYS_DONE)
    else $error("done without request");
  a_read_fields: assert property (rd_ctl && o_SYS_RESULT == 3'h0 |->
    o_SYS_RDATA[31:11] == {18'h0, IDW} && o_SYS_RDATA[10:8] == PRI &&
    !o_SYS_RDATA[7] && o_SYS_RDATA[5:2] == 4'h0) else $error("control read fields wrong");
  a_undef_sre: assert property (i_SYS_VALID && !i_SYSREG_ENABLE && (is_ctl || is_dir)
    |=> o_SYS_RESULT == 3'h1) else $error("disabled access not undefined");
  a_ctl_virtual: assert property (s_ctl_virt |=> o_SYS_RESULT == 3'h4)
    else $error("control access not redirected");
  a_eoi_effect: assert property (s_eoi_alone |=>
    o_PRIORITY_DROP && o_DEACTIVATE == !$past(o_SPLIT_EOI_MODE)) else $error("eoi effect wrong");
  a_dir_ident: assert property (o_DEACTIVATE && o_SYS_DONE && !$past(i_EOI_WRITE) |->
    o_SYS_RESULT == 3'h0 && o_DEACTIVATE_ID == ($past(i_SYS_WDATA[23:0]) & IDM))
    else $error("deactivate identifier wrong");
  a_err_ignored: assert property (o_SYSTEM_ERROR_IRQ |->
    o_SYS_DONE && o_SYS_RESULT == 3'h5 && !o_DEACTIVATE) else $error("ignored write acted");
  a_refuse_hold: assert property (o_SYS_DONE && o_SYS_RESULT != 3'h0 |->
    $stable(o_MASK_HINT_ENABLE) && $stable(o_COMMON_BINARY_POINT))
    else $error("refused access changed control");
  a_dir_no_drop: assert property (o_DEACTIVATE && !$past(i_EOI_WRITE) |-> !o_PRIORITY_DROP)
    else $error("deactivate write dropped priority");
endmodule // cicd_chk
bind cicd_top cicd_chk #(.TWO_SEC(TWO_SEC), .ID24(ID24)) cicd_chk_i (.*);

// [dv/cicd_cpu.sv]
// processor core model issuing system register accesses
`timescale 1ns/1ns
module cicd_cpu (
  input wire i_clk,
  input wire i_done,
  input wire [2:0] i_result,
  input wire [31:0] i_rdata,
  output reg o_valid,
  output reg o_write,
  output reg [3:0] o_crm,
  output reg [2:0] o_opc2,
  output reg [31:0] o_wdata
);
  reg [2:0] res = 3'h0;
  reg [31:0] rd = 32'h0;
  initial
  begin
    o_valid = 1'b0;
    o_write = 1'b0;
    o_crm = 4'h0;
    o_opc2 = 3'h0;
    o_wdata = 32'h0;
  end
  // one access: request held for one edge, answer taken one cycle later
  task acc(input w, input [3:0] crm, input [2:0] opc2, input [31:0] wd);
    @(negedge i_clk);
    o_valid = 1'b1;
    o_write = w;
    {o_crm, o_opc2} = {crm, opc2};
    o_wdata = wd;
    @(negedge i_clk);
    o_valid = 1'b0;
    o_wdata = ~wd;
    res = i_done ? i_result : 3'h7;
    rd = i_rdata;
  endtask
endmodule // cicd_cpu

// [dv/tb_cicd_top.sv]
// self-checking bench for the cpu interface control and deactivate block
`timescale 1ns/1ns
module tb_cicd_top;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg ds = 1'b0;
  reg eoi = 1'b0;
  // context: enable, secure, fiq route, irq route, trap, monitor, group one
  reg [6:0] c = 7'h60;
  wire valid, wr, done, mask_hint_enable, cbp, mode, drop, deact, serr;
  wire [3:0] crm;
  wire [2:0] opc2, res;
  wire [31:0] wd, rdata;
  wire [23:0] did;
  integer fails = 0;
  integer n_tests = 0;
  always #10 clk = ~clk;
  cicd_cpu cicd_cpu_i (.i_clk(clk), .i_done(done), .i_result(res), .i_rdata(rdata),
    .o_valid(valid), .o_write(wr), .o_crm(crm), .o_opc2(opc2), .o_wdata(wd));
  cicd_top cicd_top_i (.I_CORE_CLK(clk), .I_RST_N(rst_n), .i_SYS_VALID(valid),
    .i_SYS_WRITE(wr), .i_SYS_COPROC(4'hF), .i_SYS_OPC1(3'h0), .i_SYS_CRN(4'hC),
    .i_SYS_CRM(crm), .i_SYS_OPC2(opc2), .i_SYS_WDATA(wd), .i_SYS_EL(2'h1),
    .i_SYS_SECURE(c[5]), .i_SYSREG_ENABLE(c[6]), .i_HYP_FIQ_ROUTE(c[4]),
    .i_HYP_IRQ_ROUTE(c[3]), .i_HYP_TRAP_COMMON(c[2]), .i_EL3_WIDE(1'b1), .i_MON_FIQ(c[1]),
    .i_MON_IRQ(c[1]), .i_DIST_SINGLE_SECURITY(ds), .i_ID_GROUP1(c[0]), .i_EOI_WRITE(eoi),
    .o_SYS_DONE(done), .o_SYS_RESULT(res), .o_SYS_RDATA(rdata), .o_MASK_HINT_ENABLE(mask_hint_enable),
    .o_COMMON_BINARY_POINT(cbp), .o_SPLIT_EOI_MODE(mode), .o_PRIORITY_DROP(drop),
    .o_DEACTIVATE(deact), .o_DEACTIVATE_ID(did), .o_SYSTEM_ERROR_IRQ(serr));
  task chk(input string nm, input [31:0] e, input [31:0] g);
    n_tests = n_tests + 1;
    if (g !== e)
    begin
      fails = fails + 1;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task final_report;
    if (fails == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task acc(input w, input d, input [31:0] v);
    cicd_cpu_i.acc(w, d ? 4'hB : 4'hC, d ? 3'h1 : 3'h4, v);
  endtask
  task t_ctl;
    acc(1'b0, 1'b0, 32'h0);
    chk("ctl_rst", 32'h00000C00, cicd_cpu_i.rd);
    ds = 1'b1;
    repeat (3) @(negedge clk);
    acc(1'b1, 1'b0, 32'hFFFFFFFF);
    chk("hint", 1'b1, mask_hint_enable);
    chk("cbp", 1'b1, cbp);
    acc(1'b0, 1'b0, 32'h0);
    chk("ctl_rd", 32'h00000C43, cicd_cpu_i.rd);
    ds = 1'b0;
    repeat (3) @(negedge clk);
    acc(1'b1, 1'b0, 32'h00000002);
    acc(1'b0, 1'b0, 32'h0);
    chk("ctl_ro", 32'h00000C43, cicd_cpu_i.rd);
  endtask
  task pulse_eoi(input exp_d);
    @(negedge clk);
    eoi = 1'b1;
    @(negedge clk);
    eoi = 1'b0;
    chk("drop", 1'b1, drop);
    chk("eoi_deact", exp_d, deact);
  endtask
  task t_split;
    c[5] = 1'b0;
    acc(1'b0, 1'b0, 32'h0);
    chk("ns_rd", 32'h00000C41, cicd_cpu_i.rd);
    pulse_eoi(1'b1);
    acc(1'b1, 1'b1, 32'h00000055);
    chk("ign_res", 3'h5, cicd_cpu_i.res);
    chk("ign_serr", 1'b1, serr);
    chk("ign_deact", 1'b0, deact);
    c[5] = 1'b1;
    @(negedge clk);
    chk("s_mode", 1'b1, mode);
    pulse_eoi(1'b0);
    acc(1'b1, 1'b1, 32'hAB123456);
    chk("dir_res", 3'h0, cicd_cpu_i.res);
    chk("dir_deact", 1'b1, deact);
    chk("dir_id", 24'h123456, did);
    chk("dir_nodrop", 1'b0, drop);
  endtask
  task tr(input [6:0] cv, input d, input [2:0] e);
    c = cv;
    acc(1'b1, d, 32'h00000000);
    chk("refused", e, cicd_cpu_i.res);
    chk("hold_hint", 1'b1, mask_hint_enable);
    chk("hold_cbp", 1'b1, cbp);
  endtask
  task t_refuse;
    ds = 1'b1;
    repeat (3) @(negedge clk);
    tr(7'b0100000, 1'b0, 3'h1);
    tr(7'b1010000, 1'b0, 3'h4);
    tr(7'b1001000, 1'b0, 3'h4);
    tr(7'b1010000, 1'b1, 3'h4);
    tr(7'b1001001, 1'b1, 3'h4);
    tr(7'b1001100, 1'b1, 3'h2);
    tr(7'b1100010, 1'b1, 3'h3);
    c = 7'h60;
    acc(1'b0, 1'b1, 32'h0);
    chk("dir_read", 3'h6, cicd_cpu_i.res);
    cicd_cpu_i.acc(1'b0, 4'hD, 3'h4, 32'h0);
    chk("bad_enc", 3'h6, cicd_cpu_i.res);
  endtask
  initial
  begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    t_ctl;
    t_split;
    t_refuse;
    final_report;
  end
  initial
  begin
    #20000;
    fails = fails + 1;
    final_report;
  end
endmodule // tb_cicd_top
